// ===== design/bstp_pkg.sv
`default_nettype none
`include "bstp_regs.svh"

package bstp_pkg;

    // tap controller states, gray steps along the scan path
    typedef enum logic [3:0] {
        ST_RESET   = 4'h0,
        ST_IDLE    = 4'h1,
        ST_SEL_DR  = 4'h3,
        ST_CAP_DR  = 4'h2,
        ST_SH_DR   = 4'h6,
        ST_EX1_DR  = 4'h7,
        ST_PA_DR   = 4'h5,
        ST_EX2_DR  = 4'h4,
        ST_UPD_DR  = 4'hC,
        ST_SEL_IR  = 4'hD,
        ST_CAP_IR  = 4'hF,
        ST_SH_IR   = 4'hE,
        ST_EX1_IR  = 4'hA,
        ST_PA_IR   = 4'hB,
        ST_EX2_IR  = 4'h9,
        ST_UPD_IR  = 4'h8
    } bstp_state_t;

    // whole module state, registered as one word
    typedef struct packed {
        logic                         tck_m;
        logic                         tck_s;
        logic                         tck_d;
        logic                         tms_m;
        logic                         tms_s;
        logic                         tdi_m;
        logic                         tdi_s;
        logic                         trst_m;
        logic                         trst_s;
        bstp_state_t                  state;
        logic [`BSTP_IR_LEN-1:0]      ir;
        logic [`BSTP_IR_LEN-1:0]      ir_sh;
        logic [`BSTP_DR_LEN-1:0]      dr_sh;
        logic                         tdo;
        logic                         tdo_oe;
    } bstp_regs_t;

endpackage

`default_nettype wire

// ===== design/bstp_regs.svh
`ifndef BSTP_REGS_SVH
`define BSTP_REGS_SVH

// instruction register layout
`define BSTP_IR_LEN      4
`define BSTP_IR_CAPTURE  4'h1
`define BSTP_OP_IDCODE   4'h1
`define BSTP_OP_BYPASS   4'hF

// identification register, value is arbitrary, bit 0 must stay one
`define BSTP_IDCODE      32'h0BAD_C0D1
`define BSTP_DR_LEN      32

`endif

// ===== design/bstp_tap.sv
`include "bstp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bstp_tap #(
    parameter int IR_LEN = `BSTP_IR_LEN  // instruction register width
) (
    input  wire logic       mclk,       // 20 MHz system clock
    input  wire logic       rst_n,      // synchronous reset, low active
    input  wire logic       tck_pin,    // test clock from tester
    input  wire logic       tms_pin,    // mode select level
    input  wire logic       tms_drv,    // mode select actually driven
    input  wire logic       tdi_pin,    // serial data in level
    input  wire logic       tdi_drv,    // data in actually driven
    input  wire logic       trst_n_pin, // test reset level, low active
    input  wire logic       trst_drv,   // test reset actually driven
    output logic            tdo_out,    // serial data out
    output logic            tdo_oe,     // data out enable, high drives
    output logic [3:0]      tap_state   // current controller state
);

    // width check: storage is laid out from the shared header
    if (IR_LEN != `BSTP_IR_LEN || IR_LEN < 2)
    begin : g_bad_ir_len
        $error("bstp_tap: IR_LEN must equal the header width");
    end

    bstp_pkg::bstp_regs_t st;
    bstp_pkg::bstp_regs_t next_st;

    logic tck_rise;
    logic tck_fall;
    logic tms_eff;
    logic tdi_eff;
    logic trst_eff;

    // edges from the synchronised clock copy only
    assign tck_rise = st.tck_s & ~st.tck_d;
    assign tck_fall = ~st.tck_s & st.tck_d;

    // internal pull-ups: an undriven pin reads one
    assign tms_eff  = tms_drv ? tms_pin : 1'h1;
    assign tdi_eff  = tdi_drv ? tdi_pin : 1'h1;
    assign trst_eff = trst_drv ? trst_n_pin : 1'h1;

    // tap transition table, one step per rising test clock edge
    function automatic bstp_pkg::bstp_state_t tap_step(
        input bstp_pkg::bstp_state_t s,
        input logic                  m
    );
        case (s)
            bstp_pkg::ST_RESET:  tap_step = m ? bstp_pkg::ST_RESET
                                               : bstp_pkg::ST_IDLE;
            bstp_pkg::ST_IDLE:   tap_step = m ? bstp_pkg::ST_SEL_DR
                                               : bstp_pkg::ST_IDLE;
            bstp_pkg::ST_SEL_DR: tap_step = m ? bstp_pkg::ST_SEL_IR
                                               : bstp_pkg::ST_CAP_DR;
            bstp_pkg::ST_CAP_DR: tap_step = m ? bstp_pkg::ST_EX1_DR
                                               : bstp_pkg::ST_SH_DR;
            bstp_pkg::ST_SH_DR:  tap_step = m ? bstp_pkg::ST_EX1_DR
                                               : bstp_pkg::ST_SH_DR;
            bstp_pkg::ST_EX1_DR: tap_step = m ? bstp_pkg::ST_UPD_DR
                                               : bstp_pkg::ST_PA_DR;
            bstp_pkg::ST_PA_DR:  tap_step = m ? bstp_pkg::ST_EX2_DR
                                               : bstp_pkg::ST_PA_DR;
            bstp_pkg::ST_EX2_DR: tap_step = m ? bstp_pkg::ST_UPD_DR
                                               : bstp_pkg::ST_SH_DR;
            bstp_pkg::ST_UPD_DR: tap_step = m ? bstp_pkg::ST_SEL_DR
                                               : bstp_pkg::ST_IDLE;
            bstp_pkg::ST_SEL_IR: tap_step = m ? bstp_pkg::ST_RESET
                                               : bstp_pkg::ST_CAP_IR;
            bstp_pkg::ST_CAP_IR: tap_step = m ? bstp_pkg::ST_EX1_IR
                                               : bstp_pkg::ST_SH_IR;
            bstp_pkg::ST_SH_IR:  tap_step = m ? bstp_pkg::ST_EX1_IR
                                               : bstp_pkg::ST_SH_IR;
            bstp_pkg::ST_EX1_IR: tap_step = m ? bstp_pkg::ST_UPD_IR
                                               : bstp_pkg::ST_PA_IR;
            bstp_pkg::ST_PA_IR:  tap_step = m ? bstp_pkg::ST_EX2_IR
                                               : bstp_pkg::ST_PA_IR;
            bstp_pkg::ST_EX2_IR: tap_step = m ? bstp_pkg::ST_UPD_IR
                                               : bstp_pkg::ST_SH_IR;
            bstp_pkg::ST_UPD_IR: tap_step = m ? bstp_pkg::ST_SEL_DR
                                               : bstp_pkg::ST_IDLE;
            default:             tap_step = bstp_pkg::ST_RESET;
        endcase
    endfunction

    // next state of the whole port
    always_comb
    begin
        next_st = st;
        // two-flop synchronisers, first stage feeds only the second
        next_st.tck_m  = tck_pin;
        next_st.tck_s  = st.tck_m;
        next_st.tck_d  = st.tck_s;
        next_st.tms_m  = tms_eff;
        next_st.tms_s  = st.tms_m;
        next_st.tdi_m  = tdi_eff;
        next_st.tdi_s  = st.tdi_m;
        next_st.trst_m = trst_eff;
        next_st.trst_s = st.trst_m;

        if (!st.trst_s)
        begin
            // test reset acts on its own, no clock edge needed
            next_st.state  = bstp_pkg::ST_RESET;
            next_st.ir     = `BSTP_OP_IDCODE;
            next_st.tdo_oe = 1'h0;
        end
        else if (tck_rise)
        begin
            // sampled inputs used only on the rising edge
            next_st.state = tap_step(st.state, st.tms_s);
            case (st.state)
                bstp_pkg::ST_RESET:
                    next_st.ir = `BSTP_OP_IDCODE;
                bstp_pkg::ST_CAP_IR:
                    next_st.ir_sh = `BSTP_IR_CAPTURE;
                bstp_pkg::ST_SH_IR:
                    next_st.ir_sh = {st.tdi_s, st.ir_sh[IR_LEN-1:1]};
                bstp_pkg::ST_UPD_IR:
                    next_st.ir = st.ir_sh;
                bstp_pkg::ST_CAP_DR:
                    // bypass captures zero, the one-bit path
                    next_st.dr_sh = (st.ir == `BSTP_OP_IDCODE) ?
                                    `BSTP_IDCODE : '0;
                bstp_pkg::ST_SH_DR:
                    if (st.ir == `BSTP_OP_IDCODE)
                        next_st.dr_sh = {st.tdi_s,
                                         st.dr_sh[`BSTP_DR_LEN-1:1]};
                    else
                        next_st.dr_sh[0] = st.tdi_s;
                default:
                    next_st.ir = st.ir;
            endcase
        end
        else if (tck_fall)
        begin
            // output moves half a cycle after sampling, so holds on rise
            next_st.tdo_oe = (st.state == bstp_pkg::ST_SH_IR) ||
                             (st.state == bstp_pkg::ST_SH_DR);
            if (st.state == bstp_pkg::ST_SH_IR)
                next_st.tdo = st.ir_sh[0];
            else if (st.state == bstp_pkg::ST_SH_DR)
                next_st.tdo = st.dr_sh[0];
        end
    end

    // single state register, synchronous system reset
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st        <= '0;
            st.tck_m  <= 1'h0;
            st.tms_m  <= 1'h1;
            st.tms_s  <= 1'h1;
            st.tdi_m  <= 1'h1;
            st.tdi_s  <= 1'h1;
            st.trst_m <= 1'h1;
            st.trst_s <= 1'h1;
            st.state  <= bstp_pkg::ST_RESET;
            st.ir     <= `BSTP_OP_IDCODE;
        end
        else
            st <= next_st;
    end

    assign tdo_out   = st.tdo;
    assign tdo_oe    = st.tdo_oe;
    assign tap_state = st.state;

    // named steps used by the checks
    sequence seq_rise;
        tck_rise;
    endsequence

    sequence seq_fall;
        tck_fall;
    endsequence

    chk_tdo_on_fall: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(st.tdo) |-> $past(tck_fall))
        else $error("data out moved off a falling edge");

    chk_oe_in_shift: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(st.tdo_oe) |-> $past(tck_fall) &&
            ($past(st.state) == bstp_pkg::ST_SH_IR ||
             $past(st.state) == bstp_pkg::ST_SH_DR))
        else $error("data out enabled outside a shift state");

    chk_idle_entry: assert property (@(posedge mclk) disable iff (!rst_n)
        (seq_rise ##0 (st.state == bstp_pkg::ST_RESET && !st.tms_s
            && st.trst_s)) |=> st.state == bstp_pkg::ST_IDLE)
        else $error("mode select low did not leave reset state");

    chk_shift_exit: assert property (@(posedge mclk) disable iff (!rst_n)
        (seq_rise ##0 (st.state == bstp_pkg::ST_SH_DR && st.tms_s
            && st.trst_s)) |=> st.state == bstp_pkg::ST_EX1_DR)
        else $error("mode select high did not leave data shift");

    // mode select and data in pull-ups checked alone: the bench also keeps test reset floating
    chk_pullup_high: assert property (@(posedge mclk) disable iff (!rst_n)
        (!tms_drv) [*3] |-> st.tms_s)
        else $error("undriven mode select did not read as one");

    chk_pullup_tdi: assert property (@(posedge mclk) disable iff (!rst_n)
        (!tdi_drv) [*3] |-> st.tdi_s)
        else $error("undriven data in did not read as one");

    chk_trst_force: assert property (@(posedge mclk) disable iff (!rst_n)
        !st.trst_s |=> st.state == bstp_pkg::ST_RESET && !st.tdo_oe)
        else $error("test reset did not force reset state");

    chk_ir_shift_in: assert property (@(posedge mclk) disable iff (!rst_n)
        (seq_rise ##0 (st.state == bstp_pkg::ST_SH_IR && st.trst_s))
            |=> st.ir_sh[IR_LEN-1] == $past(st.tdi_s))
        else $error("data in not shifted into instruction");

    chk_step_on_rise: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(st.state) |-> $past(tck_rise) || !$past(st.trst_s))
        else $error("state moved without a rising edge");

    chk_tdo_stable: assert property (@(posedge mclk) disable iff (!rst_n)
        seq_fall ##1 !tck_fall [*2] |-> $stable(st.tdo))
        else $error("data out changed between falling edges");

endmodule // bstp_tap

`default_nettype wire

// ===== testbench/bstp_tester.sv
`timescale 1ns/1ps
`default_nettype none

// tester side of the test port; test clock stands high between steps
module bstp_tester (
    output logic      tck_pin,    // test clock
    output logic      tms_pin,    // mode select level
    output logic      tms_drv,    // mode select driven
    output logic      tdi_pin,    // data in level
    output logic      tdi_drv,    // data in driven
    output logic      trst_n_pin, // test reset level
    output logic      trst_drv,   // test reset driven
    input  wire logic tdo_line    // resolved data out wire
);
    // power-up: clock parked low, test reset pulsed low
    initial
    begin
        tck_pin = 1'b0;
        tms_pin = 1'b1;
        tms_drv = 1'b1;
        tdi_pin = 1'b0;
        tdi_drv = 1'b1;
        trst_n_pin = 1'b0;
        trst_drv = 1'b1;
    end

    // released pin shows the inverse of its last level, never the pull-up
    task automatic set_trst(input logic lvl);
        trst_drv = ~lvl;
        trst_n_pin = lvl ? ~trst_n_pin : 1'b0;
    endtask

    // one test clock: fall, new mode and data, rise, sample data out late
    task automatic step(input logic m, input logic d, input logic md,
                        input logic dd, output logic q);
        tck_pin = 1'b0;
        tms_pin = md ? m : ~tms_pin;
        tms_drv = md;
        tdi_pin = dd ? d : ~tdi_pin;
        tdi_drv = dd;
        #200;
        tck_pin = 1'b1;
        #199;
        q = tdo_line;
        #1;
    endtask

    // drop the clock and let the synchronised state settle
    task automatic park;
        tck_pin = 1'b0;
        #300;
    endtask
endmodule // bstp_tester

`default_nettype wire

// ===== testbench/tb_top.sv
`include "bstp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        mclk;
    logic        rst_n;
    wire logic   tck_pin, tms_pin, tms_drv, tdi_pin, tdi_drv;
    wire logic   trst_n_pin, trst_drv, tdo_out, tdo_oe, tdo_line;
    wire logic [3:0] tap_state;
    int          error_cnt = 0;
    int          cmp_count = 0;
    logic        q;
    logic [31:0] w;

    // the pin floats when the enable is low
    assign tdo_line = tdo_oe ? tdo_out : 1'bz;

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    bstp_tap dut (.mclk(mclk), .rst_n(rst_n), .tck_pin(tck_pin),
        .tms_pin(tms_pin), .tms_drv(tms_drv), .tdi_pin(tdi_pin),
        .tdi_drv(tdi_drv), .trst_n_pin(trst_n_pin), .trst_drv(trst_drv),
        .tdo_out(tdo_out), .tdo_oe(tdo_oe), .tap_state(tap_state));
    bstp_tester tester (.tck_pin(tck_pin), .tms_pin(tms_pin),
        .tms_drv(tms_drv), .tdi_pin(tdi_pin), .tdi_drv(tdi_drv),
        .trst_n_pin(trst_n_pin), .trst_drv(trst_drv), .tdo_line(tdo_line));

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t ns: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t ns: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_state(input bstp_pkg::bstp_state_t exp);
        cmp_vec({28'h000_0000, tap_state}, {28'h000_0000, exp});
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // mode select sequence, lsb first, data in driven low
    task automatic walk(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++)
            tester.step(seq[i], 1'b0, 1'b1, 1'b1, q);
    endtask

    // n shift clocks, the last one leaves the shift state
    task automatic shift(input logic [31:0] din, input int n, input logic dd,
                         output logic [31:0] dout);
        dout = 32'h0000_0000;
        for (int i = 0; i < n; i++)
        begin
            tester.step(i == n - 1, din[i], 1'b1, dd, q);
            dout[i] = q;
        end
    endtask

    task automatic t_reset;
        cmp_state(bstp_pkg::ST_RESET);
        cmp_bit(tdo_line, 1'bz);
        $display("test reset state done");
    endtask

    // checks each step of the walk into the data shift state
    task automatic t_idcode;
        bstp_pkg::bstp_state_t exp_st [4];
        exp_st = '{bstp_pkg::ST_IDLE, bstp_pkg::ST_SEL_DR,
                   bstp_pkg::ST_CAP_DR, bstp_pkg::ST_SH_DR};
        for (int i = 0; i < 4; i++)
        begin
            tester.step(i == 1, 1'b0, 1'b1, 1'b1, q);
            tester.park();
            cmp_state(exp_st[i]);
        end
        shift(32'h0000_0000, `BSTP_DR_LEN, 1'b1, w);
        cmp_vec(w, `BSTP_IDCODE);
        tester.step(1'b1, 1'b0, 1'b1, 1'b1, q);
        cmp_bit(q, 1'bz);
        walk(8'h00, 1);
        $display("test identification scan done");
    endtask

    // floating mode select must read one: five clocks reach reset
    task automatic t_tms_float;
        walk(8'h01, 3);
        for (int i = 0; i < 5; i++)
            tester.step(1'b0, 1'b0, 1'b0, 1'b1, q);
        tester.park();
        cmp_state(bstp_pkg::ST_RESET);
        walk(8'h00, 1);
        $display("test floating mode select done");
    endtask

    // floating data in loads all ones, the bypass code
    task automatic t_bypass;
        walk(8'h03, 4);
        shift(32'h0000_0000, `BSTP_IR_LEN, 1'b0, w);
        cmp_vec(w, {28'h000_0000, `BSTP_IR_CAPTURE});
        walk(8'h01, 2);
        walk(8'h01, 3);
        shift(32'h0000_00A5, 9, 1'b1, w);
        cmp_vec(w, 32'h0000_014A);
        walk(8'h01, 2);
        $display("test bypass scan done");
    endtask

    // test reset mid-shift with the test clock standing still
    task automatic t_trst;
        walk(8'h01, 3);
        tester.park();
        cmp_bit(tdo_oe, 1'b1);
        tester.set_trst(1'b0);
        repeat (4) @(posedge mclk);
        #2;
        cmp_state(bstp_pkg::ST_RESET);
        cmp_bit(tdo_line, 1'bz);
        tester.set_trst(1'b1);
        repeat (3) @(posedge mclk);
        // back to the drive phase just after the system clock edge
        #2;
        $display("test async test reset done");
    endtask

    initial
    begin
        rst_n = 1'b0;
        repeat (10) @(posedge mclk);
        #2;
        rst_n = 1'b1;
        tester.set_trst(1'b1);
        repeat (3) @(posedge mclk);
        // keep every pin change off the system clock edge
        #2;
        t_reset();
        t_idcode();
        t_tms_float();
        t_bypass();
        t_trst();
        t_idcode();
        complete_run();
    end

    initial
    begin
        #200000;
        error_cnt++;
        $display("Error at %0t ns: got %h exp %h", $time, 1'b0, 1'b1);
        complete_run();
    end
endmodule // tb_top

`default_nettype wire
